// ===== inc/tic_pkg.sv
// Shared constants for the timer counter with input capture.
package tic_pkg;
  // Register byte offsets.
  localparam logic [7:0] ctrl_off      = 8'h00;
  localparam logic [7:0] edge_off      = 8'h04;
  localparam logic [7:0] count_off     = 8'h08;
  localparam logic [7:0] status_off    = 8'h0c;
  localparam logic [7:0] clear_off     = 8'h10;
  localparam logic [7:0] enable_off    = 8'h14;
  localparam logic [7:0] pins_off      = 8'h18;
  localparam logic [7:0] cap_base_off  = 8'h20;
  localparam logic [7:0] cc4_write_off = 8'h30;
  localparam logic [7:0] pin_out_off   = 8'h34;
  // Control register fields.
  localparam int prescale_lo_bit = 0;
  localparam int sel4_bit        = 2;
  localparam int dir_bit         = 3;
  // Status bits: four captures then overflow.
  localparam int ovf_bit         = 4;
  localparam int num_flags       = 5;
  localparam int num_chan        = 4;
  localparam logic [15:0] count_reset = 16'h0000;
  localparam logic [15:0] compare_reset = 16'hffff;
  // Prescale division ratios.
  localparam logic [4:0] div_1  = 5'h01;
  localparam logic [4:0] div_4  = 5'h04;
  localparam logic [4:0] div_8  = 5'h08;
  localparam logic [4:0] div_16 = 5'h10;
  // Edge select encodings.
  localparam logic [1:0] edge_off_code  = 2'h0;
  localparam logic [1:0] edge_rise_code = 2'h1;
  localparam logic [1:0] edge_fall_code = 2'h2;
  localparam logic [1:0] edge_any_code  = 2'h3;
  // Bus responses.
  localparam logic [1:0] resp_okay   = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
endpackage : tic_pkg

// ===== hdl/tic_prescaler.sv
// Prescaler producing the counter increment tick.
`timescale 1ns/1ps
module tic_prescaler (
  // Clock and reset.
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Ratio select.
  input  wire logic [1:0] sel,
  // Increment tick.
  output logic            tick
);
  logic [4:0] cnt_reg;
  logic [4:0] ratio;

  // Ratio decode: 00, 01, 10, 11 give 1, 4, 8, 16.
  always_comb begin
    case (sel)
      2'h0:    ratio = tic_pkg::div_1;
      2'h1:    ratio = tic_pkg::div_4;
      2'h2:    ratio = tic_pkg::div_8;
      default: ratio = tic_pkg::div_16;
    endcase
  end

  // The ratio compare uses >= so a mid-run ratio change never stalls the chain.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 5'h00;
    end else if (cnt_reg + 5'h01 >= ratio) begin
      cnt_reg <= 5'h00;
    end else begin
      cnt_reg <= cnt_reg + 5'h01;
    end
  end

  assign tick = aresetn && (cnt_reg + 5'h01 >= ratio);
endmodule : tic_prescaler

// ===== hdl/tic_edge_detect.sv
// Pin synchroniser and selectable edge detector for one capture channel.
`timescale 1ns/1ps
module tic_edge_detect (
  // Clock and reset.
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Pin and mode.
  input  wire logic       pin,
  input  wire logic [1:0] mode,
  // Results.
  output logic            level,
  output logic            hit
);
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;

  // Two-stage synchroniser, then one history stage for edge finding.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg  <= 1'b0;
    end else begin
      sync1_reg <= pin;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  assign level = sync2_reg;
  // Edge decode per mode.
  always_comb begin
    case (mode)
      tic_pkg::edge_rise_code: hit = sync2_reg && !prev_reg;
      tic_pkg::edge_fall_code: hit = !sync2_reg && prev_reg;
      tic_pkg::edge_any_code:  hit = sync2_reg ^ prev_reg;
      default:                 hit = 1'b0;
    endcase
  end
endmodule : tic_edge_detect

// ===== hdl/tic_timer_capture.sv
// Free-running timer with four input capture channels and AXI4-Lite registers.
// Notes on behaviour
// - Prescaler divides clock by 1, 4, 8, 16.
// - Sixteen-bit up-counter starting at zero after reset.
// - Wrap to zero, flag overflow, keep counting.
// - Software cannot load, reset or halt counter.
// - Each channel latches count on selected edge.
// - Synchronise edges; capture on same edge counter moves.
// - Pin levels readable at any time.
// - Shared pin captures only when select set.
// - Shared pin direction resets to input.
// - Driven shared pin edges still trigger captures.
// - Writes to shared register ignored while capturing.
// - Edge codes: off, rising, falling, both.
// - Four edge fields reset to disabled.
// - Channels independent; same period gives same count.
// - Each function has own flag and enable.
// - Whole count moved at once; no reset.
// - High read blocks capture one cycle, delays.
`timescale 1ns/1ps
module tic_timer_capture (
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data.
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address.
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data.
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Capture pins; bit 3 is the shared pin.
  input  wire logic [3:0]  capture_pins,
  output logic             shared_capture_pin_o,
  output logic             shared_capture_pin_oe,
  // Interrupt.
  output logic             irq
);
  localparam int nc = tic_pkg::num_chan;
  localparam int nf = tic_pkg::num_flags;

  logic [15:0]   free_running_count_reg;
  logic [3:0]    ctrl_reg;
  logic [7:0]    timer_edge_control_reg;
  logic [nf-1:0] status_reg;
  logic [nf-1:0] enable_reg;
  logic [15:0]   cap_reg [nc];
  logic [15:0]   cc4_store_reg;
  logic          pin_out_reg;
  logic [nc-1:0] pend_reg;
  logic [nc-1:0] block_reg;
  logic [nc-1:0] hit;
  logic [nc-1:0] lvl;
  logic [nc-1:0] take;
  logic          tick;
  logic          fourth_capture_select;
  logic          shared_pin_direction;
  logic          aw_held_reg;
  logic          w_held_reg;
  logic [7:0]    awaddr_reg;
  logic [31:0]   wdata_reg;
  logic [3:0]    wstrb_reg;
  logic          wr_fire;
  logic          rd_fire;
  logic [nf-1:0] clear_mask;
  logic [31:0]   rd_value;
  logic          rd_ok;
  logic          wr_ok;

  assign fourth_capture_select = ctrl_reg[tic_pkg::sel4_bit];
  assign shared_pin_direction  = ctrl_reg[tic_pkg::dir_bit];

  // Counter tick source.
  tic_prescaler u_prescaler (
    .aclk    (aclk),
    .aresetn (aresetn),
    .sel     (ctrl_reg[tic_pkg::prescale_lo_bit +: 2]),
    .tick    (tick)
  );

  // One edge detector per channel; channel 3 needs the select bit set.
  genvar g;
  generate
    for (g = 0; g < nc; g++) begin : g_chan
      logic [1:0] mode;
      assign mode = (g == nc - 1 && !fourth_capture_select) ? tic_pkg::edge_off_code
                  : timer_edge_control_reg[2*g +: 2];
      tic_edge_detect u_edge (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin     (capture_pins[g]),
        .mode    (mode),
        .level   (lvl[g]),
        .hit     (hit[g])
      );
      // A held-off capture stays pending and is taken the next cycle.
      assign take[g] = (hit[g] || pend_reg[g]) && !block_reg[g];

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pend_reg[g] <= 1'b0;
        end else begin
          pend_reg[g] <= (hit[g] || pend_reg[g]) && block_reg[g];
        end
      end

      // Captures are not cleared by reset and sample the count on the
      // same edge it moves on, taking the value held before the step.
      always_ff @(posedge aclk) begin
        if (take[g]) begin
          cap_reg[g] <= free_running_count_reg;
        end
      end
    end
  endgenerate

  // Free-running counter; no bus path touches it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      free_running_count_reg <= tic_pkg::count_reset;
    end else if (tick) begin
      free_running_count_reg <= free_running_count_reg + 16'h0001;
    end
  end

  // Bus handshakes: address and data captured in either order.
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      awaddr_reg    <= 8'h00;
      wdata_reg     <= 32'h0000_0000;
      wstrb_reg     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= tic_pkg::resp_okay;
    end else begin
      s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? tic_pkg::resp_okay : tic_pkg::resp_slverr;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Write decode; the count register is read-only.
  always_comb begin
    case (awaddr_reg)
      tic_pkg::ctrl_off, tic_pkg::edge_off, tic_pkg::clear_off,
      tic_pkg::enable_off, tic_pkg::cc4_write_off, tic_pkg::pin_out_off: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // Control, edge, enable and shared-pin registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg               <= 4'h0;
      timer_edge_control_reg <= 8'h00;
      enable_reg             <= '0;
      cc4_store_reg          <= tic_pkg::compare_reset;
      pin_out_reg            <= 1'b0;
    end else if (wr_fire && wstrb_reg[0]) begin
      case (awaddr_reg)
        tic_pkg::ctrl_off:    ctrl_reg <= wdata_reg[3:0];
        tic_pkg::edge_off:    timer_edge_control_reg <= wdata_reg[7:0];
        tic_pkg::enable_off:  enable_reg <= wdata_reg[nf-1:0];
        tic_pkg::pin_out_off: pin_out_reg <= wdata_reg[0];
        tic_pkg::cc4_write_off: begin
          if (!fourth_capture_select) begin
            cc4_store_reg <= wdata_reg[15:0];
          end
        end
        default: ;
      endcase
    end
  end

  // Driving the shared pin feeds back through the pin input, so toggles
  // capture like external edges.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shared_capture_pin_oe <= 1'b0;
      shared_capture_pin_o  <= 1'b0;
    end else begin
      shared_capture_pin_oe <= shared_pin_direction;
      shared_capture_pin_o  <= pin_out_reg;
    end
  end

  assign clear_mask = (wr_fire && wstrb_reg[0] && awaddr_reg == tic_pkg::clear_off)
                    ? wdata_reg[nf-1:0] : '0;

  // Sticky flags; a new event wins over a simultaneous clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= '0;
    end else begin
      status_reg <= (status_reg & ~clear_mask)
                  | {tick && (free_running_count_reg == 16'hffff), take};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_reg & enable_reg);
    end
  end

  // Read mux; capture words carry the high byte in bits 15:8.
  always_comb begin
    rd_value = 32'h0000_0000;
    rd_ok    = 1'b1;
    case (s_axi_araddr)
      tic_pkg::ctrl_off:    rd_value[3:0] = ctrl_reg;
      tic_pkg::edge_off:    rd_value[7:0] = timer_edge_control_reg;
      tic_pkg::count_off:   rd_value[15:0] = free_running_count_reg;
      tic_pkg::status_off:  rd_value[nf-1:0] = status_reg;
      tic_pkg::enable_off:  rd_value[nf-1:0] = enable_reg;
      tic_pkg::pins_off:    rd_value[3:0] = lvl;
      tic_pkg::pin_out_off: rd_value[0] = pin_out_reg;
      tic_pkg::cc4_write_off: begin
        rd_value[15:0] = fourth_capture_select ? cap_reg[nc-1] : cc4_store_reg;
      end
      tic_pkg::cap_base_off:         rd_value[15:0] = cap_reg[0];
      tic_pkg::cap_base_off + 8'h04: rd_value[15:0] = cap_reg[1];
      tic_pkg::cap_base_off + 8'h08: rd_value[15:0] = cap_reg[2];
      tic_pkg::cap_base_off + 8'h0c: rd_value[15:0] = cap_reg[3];
      tic_pkg::clear_off:   rd_value = 32'h0000_0000;
      default:              rd_ok = 1'b0;
    endcase
  end

  // Read channel; reading a capture word holds off that channel one cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= tic_pkg::resp_okay;
      block_reg     <= '0;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      block_reg     <= '0;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_value;
        s_axi_rresp  <= rd_ok ? tic_pkg::resp_okay : tic_pkg::resp_slverr;
        for (int i = 0; i < nc; i++) begin
          if (s_axi_araddr == tic_pkg::cap_base_off + 8'(4 * i)) begin
            block_reg[i] <= 1'b1;
          end
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Checks.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  count_wrap_a: assert property (tick && free_running_count_reg == 16'hffff |=>
    free_running_count_reg == 16'h0000 && status_reg[tic_pkg::ovf_bit])
    else $error("Counter did not wrap with overflow flag.");
  count_step_a: assert property (!tick |=> $stable(free_running_count_reg))
    else $error("Counter moved without a tick.");
  count_inc_a: assert property (tick |=>
    free_running_count_reg == $past(free_running_count_reg) + 16'h0001)
    else $error("Counter did not increment.");
  cap_load_a: assert property (take[0] |=> cap_reg[0] == $past(free_running_count_reg))
    else $error("Capture value wrong.");
  cap_flag_a: assert property (take[1] |=> status_reg[1])
    else $error("Capture flag not set.");
  block_delay_a: assert property (hit[2] && block_reg[2] |=> take[2])
    else $error("Blocked capture lost.");
  shared_off_a: assert property (!fourth_capture_select |-> !hit[3])
    else $error("Shared channel captured while deselected.");
  irq_level_a: assert property (|(status_reg & enable_reg) |=> irq)
    else $error("Interrupt missing.");
  cc4_ignore_a: assert property (fourth_capture_select && $stable(ctrl_reg) |=>
    $stable(cc4_store_reg))
    else $error("Shared register written during capture.");

  cap_seen_c: cover property (take[0] ##1 take[1]);
  wrap_seen_c: cover property (status_reg[tic_pkg::ovf_bit]);
  delay_seen_c: cover property (hit[2] && block_reg[2]);
endmodule : tic_timer_capture

// ===== test/tic_pin_model.sv
// Behavioural model of the external event signals on the four capture pins.
`timescale 1ns/1ps
module tic_pin_model (
  // Levels requested by the bench.
  input  wire logic [3:0] drive,
  // Shared pin driver of the timer.
  input  wire logic       pin_o,
  input  wire logic       pin_oe,
  // Pin levels seen by the timer.
  output logic [3:0]      capture_pins
);
  // The shared pin follows the timer while it drives, so driven edges reach capture too.
  assign capture_pins[3] = pin_oe ? pin_o : drive[3];
  // The other pins carry the external levels straight through.
  assign capture_pins[2:0] = drive[2:0];
endmodule : tic_pin_model

// ===== test/tb.sv
// Self-checking testbench for the timer counter with input capture.
`timescale 1ns/1ps
module tb;
  logic        aclk;
  logic        aresetn;
  logic [7:0]  s_axi_awaddr;
  logic        s_axi_awvalid, s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid, s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid, s_axi_bready;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_arvalid, s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid, s_axi_rready;
  logic [3:0]  capture_pins;
  logic [3:0]  drive;
  logic        shared_capture_pin_o, shared_capture_pin_oe;
  logic        irq;
  logic [1:0]  last_resp;
  logic [31:0] rnd_state;
  int          fails;
  int          compares;

  tic_timer_capture tic_timer_capture_i (
    .aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .capture_pins, .shared_capture_pin_o, .shared_capture_pin_oe, .irq
  );

  tic_pin_model tic_pin_model_i (
    .drive        (drive),
    .pin_o        (shared_capture_pin_o),
    .pin_oe       (shared_capture_pin_oe),
    .capture_pins (capture_pins)
  );

  // Free-running clock at 200 MHz.
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // Xorshift source; a fixed seed keeps every run identical.
  function automatic logic [31:0] next_rand();
    rnd_state = rnd_state ^ (rnd_state << 13);
    rnd_state = rnd_state ^ (rnd_state >> 17);
    rnd_state = rnd_state ^ (rnd_state << 5);
    return rnd_state;
  endfunction : next_rand

  // Counter steps expected over a span measured at ratio one.
  function automatic logic [31:0] exp_ticks(input int code, input logic [31:0] cyc);
    case (code)
      0: return cyc / 32'(tic_pkg::div_1);
      1: return cyc / 32'(tic_pkg::div_4);
      2: return cyc / 32'(tic_pkg::div_8);
      default: return cyc / 32'(tic_pkg::div_16);
    endcase
  endfunction : exp_ticks

  // Whether an edge code reacts to a rising or a falling edge.
  function automatic logic exp_flag(input int code, input logic rise);
    return rise ? (2'(code) == tic_pkg::edge_rise_code || 2'(code) == tic_pkg::edge_any_code)
                : (2'(code) == tic_pkg::edge_fall_code || 2'(code) == tic_pkg::edge_any_code);
  endfunction : exp_flag

  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask : idle

  // One write; address and data are released as each is taken.
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    last_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_write

  // One read; the data is taken at the edge where rvalid is seen.
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    last_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_read

  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp

  task automatic cmp_rng(input string name, input logic [31:0] lo, input logic [31:0] hi,
                         input logic [31:0] got);
    compares++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      fails++;
      $display("FAIL %s expected %h..%h seen %h", name, lo, hi, got);
    end
  endtask : cmp_rng

  task automatic test_done();
    if (fails == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  // Watchdog sized well above the long overflow wait.
  initial begin
    repeat (100000) @(posedge aclk);
    fails++;
    test_done();
  end

  // Main sequence.
  initial begin
    logic [31:0] v, c0, c1, g0;
    int ch;
    fails = 0;
    compares = 0;
    rnd_state = 32'd91415;
    aresetn = 1'b0;
    drive = 4'h0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset state of control, edge selects, status, pin driver and counter.
    axi_read(tic_pkg::ctrl_off, v);
    cmp("ctrl_reset", 32'h0, v);
    axi_read(tic_pkg::edge_off, v);
    cmp("edge_reset", 32'h0, v);
    axi_read(tic_pkg::status_off, v);
    cmp("status_reset", 32'h0, v);
    cmp("oe_reset", 32'h0, {31'h0, shared_capture_pin_oe});
    axi_read(tic_pkg::count_off, v);
    cmp_rng("count_start", 32'h1, 32'h20, v);
    // Unmapped place is refused.
    axi_write(8'h3c, next_rand());
    cmp("bad_wr_resp", {30'h0, tic_pkg::resp_slverr}, {30'h0, last_resp});
    axi_read(8'h3c, v);
    cmp("bad_rd_resp", {30'h0, tic_pkg::resp_slverr}, {30'h0, last_resp});
    // Equal spans at each ratio; ratio one calibrates the span.
    g0 = 32'h0;
    for (int k = 0; k < 4; k++) begin
      axi_write(tic_pkg::ctrl_off, 32'(k));
      axi_read(tic_pkg::count_off, c0);
      idle(255);
      axi_read(tic_pkg::count_off, c1);
      v = (c1 - c0) & 32'hffff;
      if (k == 0) begin
        g0 = v;
        cmp_rng("count_span", 32'h100, 32'h12c, g0);
      end
      cmp_rng("count_step", exp_ticks(k, g0) - 1, exp_ticks(k, g0) + 1, v);
    end
    // A write to the counter must not disturb it.
    axi_write(tic_pkg::ctrl_off, 32'h0);
    axi_read(tic_pkg::count_off, c0);
    axi_write(tic_pkg::count_off, 32'h0);
    axi_read(tic_pkg::count_off, c1);
    cmp_rng("count_free", 32'h1, 32'h18, (c1 - c0) & 32'hffff);
    // Every edge code on a random channel, both edge directions.
    ch = int'(next_rand() % 3);
    for (int code = 0; code < 4; code++) begin
      axi_write(tic_pkg::edge_off, 32'(code) << (2 * ch));
      axi_write(tic_pkg::clear_off, 32'h1f);
      axi_read(tic_pkg::count_off, c0);
      drive[ch] <= 1'b1;
      idle(6 + int'(next_rand() % 4));
      axi_read(tic_pkg::pins_off, v);
      cmp("pins", 32'h1 << ch, v);
      axi_read(tic_pkg::status_off, v);
      cmp("rise_flag", 32'(exp_flag(code, 1'b1)) << ch, v);
      if (code[0]) begin
        axi_read(tic_pkg::cap_base_off + 8'(4 * ch), c1);
        cmp_rng("cap_time", 32'h0, 32'h10, (c1 - c0) & 32'hffff);
      end
      axi_write(tic_pkg::clear_off, 32'h1f);
      drive[ch] <= 1'b0;
      idle(6 + int'(next_rand() % 4));
      axi_read(tic_pkg::status_off, v);
      cmp("fall_flag", 32'(exp_flag(code, 1'b0)) << ch, v);
    end
    // Simultaneous edges on three channels latch one count.
    axi_write(tic_pkg::edge_off, 32'h15);
    drive <= 4'h7;
    idle(6);
    axi_read(tic_pkg::cap_base_off, c0);
    for (int i = 1; i < 3; i++) begin
      axi_read(tic_pkg::cap_base_off + 8'(4 * i), c1);
      cmp("cap_same", c0, c1);
    end
    drive <= 4'h0;
    // An edge that meets the read of its own capture word is delayed, not lost.
    // The pin rises at several offsets so that one of them lands in the held-off cycle.
    axi_write(tic_pkg::edge_off, 32'h10);
    for (int d = 0; d < 4; d++) begin
      axi_write(tic_pkg::clear_off, 32'h1f);
      fork
        begin
          idle(d);
          drive[2] <= 1'b1;
        end
        axi_read(tic_pkg::cap_base_off + 8'h08, c1);
      join
      idle(6);
      axi_read(tic_pkg::status_off, v);
      cmp("cap_held", 32'h4, v);
      drive[2] <= 1'b0;
      idle(6);
    end
    // Shared pin: ignored without select, captures with it, also when self-driven.
    axi_write(tic_pkg::edge_off, 32'hc0);
    axi_write(tic_pkg::clear_off, 32'h1f);
    drive[3] <= 1'b1;
    idle(6);
    axi_read(tic_pkg::status_off, v);
    cmp("sel_off", 32'h0, v);
    axi_write(tic_pkg::ctrl_off, 32'h4);
    drive[3] <= 1'b0;
    idle(6);
    axi_read(tic_pkg::status_off, v);
    cmp("sel_on", 32'h8, v);
    axi_write(tic_pkg::clear_off, 32'h1f);
    axi_write(tic_pkg::ctrl_off, 32'hc);
    idle(2);
    cmp("pin_oe", 32'h1, {31'h0, shared_capture_pin_oe});
    axi_write(tic_pkg::pin_out_off, 32'h1);
    idle(6);
    axi_read(tic_pkg::status_off, v);
    cmp("self_edge", 32'h8, v);
    axi_write(tic_pkg::cc4_write_off, next_rand() & 32'hffff);
    axi_read(tic_pkg::cc4_write_off, c0);
    axi_read(tic_pkg::cap_base_off + 8'hc, c1);
    cmp("cc4_kept", c1, c0);
    // Overflow sets its own flag; the interrupt obeys enable and clear.
    axi_write(tic_pkg::ctrl_off, 32'h0);
    // With the select clear the shared word shows its store, untouched by the write above.
    axi_read(tic_pkg::cc4_write_off, v);
    cmp("cc4_store", {16'h0000, tic_pkg::compare_reset}, v);
    axi_write(tic_pkg::enable_off, 32'h0);
    axi_write(tic_pkg::clear_off, 32'h1f);
    axi_read(tic_pkg::count_off, c0);
    idle(65536 - int'(c0[15:0]) + 8);
    axi_read(tic_pkg::status_off, v);
    cmp("ovf_flag", 32'h10, v);
    axi_read(tic_pkg::count_off, c1);
    cmp_rng("wrap_count", 32'h0, 32'h28, c1);
    cmp("irq_masked", 32'h0, {31'h0, irq});
    axi_write(tic_pkg::enable_off, 32'h10);
    idle(2);
    cmp("irq_on", 32'h1, {31'h0, irq});
    axi_write(tic_pkg::clear_off, 32'h10);
    idle(2);
    cmp("irq_off", 32'h0, {31'h0, irq});
    test_done();
  end
endmodule : tb
